// file: verilog/dtas_pkg.sv
/*
 * dtas_pkg: register map, field layout, reset values, channel indices and
 * timing constants for the converter trim and diagnostic-ADC register block.
 * Assumes a single 10 MHz clock domain and a plain strobe register port.
 */
package dtas_pkg;
   localparam int           DTAS_ADDR_W       = 5;
   localparam int           DTAS_DATA_W       = 16;
   localparam logic [4:0]   DTAS_OFS_GAIN     = 5'h04;
   localparam logic [4:0]   DTAS_OFS_OFFSET   = 5'h05;
   localparam logic [4:0]   DTAS_OFS_CLRCODE  = 5'h06;
   localparam logic [4:0]   DTAS_OFS_SRESET   = 5'h07;
   localparam logic [4:0]   DTAS_OFS_ADCCFG   = 5'h08;
   localparam logic [4:0]   DTAS_OFS_BOUNDS   = 5'h09;
   localparam logic [4:0]   DTAS_OFS_TRIG     = 5'h0A;
   localparam logic [4:0]   DTAS_OFS_CONVCTL  = 5'h0C;
   localparam logic [4:0]   DTAS_OFS_STATUS   = 5'h0D;
   localparam logic [15:0]  DTAS_RST_GAIN     = 16'h8000;
   localparam logic [15:0]  DTAS_RST_OFFSET   = 16'h0000;
   localparam logic [15:0]  DTAS_RST_CLRCODE  = 16'h0000;
   localparam logic [15:0]  DTAS_RST_ADCCFG   = 16'h8810;
   localparam logic [7:0]   DTAS_RST_BOUNDS   = 8'h80;
   localparam logic [7:0]   DTAS_RESET_KEY    = 8'hAD;
   // adc_config, trigger and conversion-control fields
   localparam int           DTAS_BIT_BUFPD    = 15;
   localparam int           DTAS_THRESHOLD_HYSTERESIS_LSB     = 8;
   localparam int           DTAS_THRESHOLD_HYSTERESIS_MSB     = 14;
   localparam int           DTAS_FLT_LSB      = 5;
   localparam int           DTAS_FLT_MSB      = 7;
   localparam int           DTAS_BIT_SPAN     = 4;
   localparam int           DTAS_BIT_EOCCH    = 3;
   localparam int           DTAS_RATE_LSB     = 1;
   localparam int           DTAS_RATE_MSB     = 2;
   localparam int           DTAS_BIT_DIRECT   = 0;
   localparam int           DTAS_BIT_ADCTRIG  = 0;
   localparam int           DTAS_BIT_RELOAD   = 1;
   localparam int           DTAS_BIT_FCLEAR   = 0;
   // channel indices
   localparam logic [3:0]   DTAS_CH_EXT0      = 4'h1;
   localparam logic [3:0]   DTAS_CH_EXT1      = 4'h2;
   localparam logic [3:0]   DTAS_CH_LASTNAMED = 4'h8;
   localparam logic [3:0]   DTAS_CH_GROUND    = 4'hF;
   // timing: adc clock and rates
   localparam int           DTAS_CLK_HZ       = 10_000_000;
   localparam int           DTAS_ADC_CLK_HZ   = 76_800;
   localparam int           DTAS_FIXED_RATE_HZ = 2560;
   localparam int           DTAS_ADC_DIV      = DTAS_CLK_HZ / DTAS_ADC_CLK_HZ;
   localparam int           DTAS_TICKS_3840   = DTAS_ADC_CLK_HZ / 3840;
   localparam int           DTAS_TICKS_2560   = DTAS_ADC_CLK_HZ / DTAS_FIXED_RATE_HZ;
   localparam int           DTAS_TICKS_1280   = DTAS_ADC_CLK_HZ / 1280;
   localparam int           DTAS_TICKS_640    = DTAS_ADC_CLK_HZ / 640;
   localparam int           DTAS_TICK_W       = 8;
   localparam int           DTAS_SRST_PULSE   = 1;
   typedef enum logic [1:0] {
      DTAS_IDLE = 2'b00,
      DTAS_CONV = 2'b01,
      DTAS_NEXT = 2'b11
   } dtas_seq_type;
endpackage

// file: verilog/dtas_regs.sv
/*
 * dtas_regs: converter trim registers, clear-state code, keyed soft reset,
 * diagnostic ADC configuration and a channel sequencer with trigger control.
 * Assumes a synchronous strobe register port and an external ADC core that
 * consumes adc_channel/adc_convert and a trim loader that consumes reload.
 */
`timescale 1ns/1ns
module dtas_regs
   import dtas_pkg::*;
#(
   parameter int ADC_DIV = DTAS_ADC_DIV
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [DTAS_ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [15:0]            reg_rdata,
   input  wire logic [15:0]            dac_code_in,
   output logic      [15:0]            dac_code_out,
   output logic                        soft_reset_pulse,
   output logic                        trim_reload,
   output logic                        adc_buffer_powerdown,
   output logic      [6:0]             threshold_hysteresis,
   output logic                        analog_input_span,
   output logic      [3:0]             adc_channel,
   output logic                        adc_convert,
   output logic                        conversion_done,
   input  wire logic                   fault_seen,
   input  wire logic                   fault_sample,
   output logic                        alarm_trip
);
   logic [15:0] gain_q, gain_d, offs_q, offs_d, clrc_q, clrc_d, acfg_q, acfg_d;
   logic [7:0]  bnd_q, bnd_d;
   logic        fclr_q, fclr_d, trig_q, trig_d, rel_q, rel_d, srst_q, srst_d;
   logic [15:0] rdata_q, rdata_d, code_q, code_d;
   logic [3:0]  ch_q, ch_d;
   logic [2:0]  fcnt_q, fcnt_d;
   logic        alarm_q, alarm_d, conv_q, conv_d, done_q, done_d;
   logic [7:0]  pre_q, pre_d, tick_q, tick_d;
   dtas_seq_type st_q, st_d;
   logic        direct, wr_trig, seq_end, adc_tick;
   logic [3:0]  start_idx, stop_idx;
   logic [33:0] scaled;
   logic [17:0] summed;

   function automatic logic is_wr(input logic [4:0] a, input logic [4:0] ofs);
      return reg_wr && (a == ofs);
   endfunction

   function automatic logic [7:0] conv_ticks(input logic [3:0] ch, input logic [1:0] rate);
      if (ch == DTAS_CH_EXT0 || ch == DTAS_CH_EXT1) begin
         case (rate)
            2'h0:    conv_ticks = 8'(DTAS_TICKS_3840);
            2'h1:    conv_ticks = 8'(DTAS_TICKS_2560);
            2'h2:    conv_ticks = 8'(DTAS_TICKS_1280);
            default: conv_ticks = 8'(DTAS_TICKS_640);
         endcase
      end else begin
         conv_ticks = 8'(DTAS_TICKS_2560);
      end
   endfunction

   assign direct    = acfg_q[DTAS_BIT_DIRECT];
   assign start_idx = bnd_q[3:0];
   assign stop_idx  = (bnd_q[7:4] < bnd_q[3:0]) ? bnd_q[3:0] : bnd_q[7:4];
   assign wr_trig   = is_wr(reg_addr, DTAS_OFS_TRIG);
   assign adc_tick  = (pre_q == 8'(ADC_DIV - 1));
   // an aborted sequence never counts as ended, so auto mode keeps its bit
   assign seq_end   = (st_q == DTAS_CONV) && adc_tick && (tick_q == 8'h00)
                      && (ch_q == stop_idx) && trig_q;

   // register file
   always_comb begin
      gain_d = gain_q;
      offs_d = offs_q;
      clrc_d = clrc_q;
      acfg_d = acfg_q;
      bnd_d  = bnd_q;
      fclr_d = fclr_q;
      trig_d = trig_q;
      rel_d  = 1'b0; // one-cycle reload, reads zero after
      srst_d = 1'b0;
      if (is_wr(reg_addr, DTAS_OFS_GAIN))    gain_d = reg_wdata;
      if (is_wr(reg_addr, DTAS_OFS_OFFSET))  offs_d = reg_wdata;
      if (is_wr(reg_addr, DTAS_OFS_CLRCODE)) clrc_d = reg_wdata;
      if (is_wr(reg_addr, DTAS_OFS_ADCCFG))  acfg_d = reg_wdata;
      if (is_wr(reg_addr, DTAS_OFS_BOUNDS))  bnd_d  = reg_wdata[7:0];
      if (is_wr(reg_addr, DTAS_OFS_CONVCTL)) fclr_d = reg_wdata[DTAS_BIT_FCLEAR];
      // only the key triggers the reset
      if (is_wr(reg_addr, DTAS_OFS_SRESET) && reg_wdata[7:0] == DTAS_RESET_KEY)
         srst_d = 1'b1;
      // end of direct sequence clears trigger; a same-cycle write wins
      if (seq_end && direct) trig_d = 1'b0;
      if (wr_trig) begin
         trig_d = reg_wdata[DTAS_BIT_ADCTRIG];
         rel_d  = reg_wdata[DTAS_BIT_RELOAD];
      end
      // keyed reset restores every writable field to its reset value; status is left alone
      if (srst_q) begin
         gain_d = DTAS_RST_GAIN;
         offs_d = DTAS_RST_OFFSET;
         clrc_d = DTAS_RST_CLRCODE;
         acfg_d = DTAS_RST_ADCCFG;
         bnd_d  = DTAS_RST_BOUNDS;
         fclr_d = 1'b0;
         trig_d = 1'b0;
      end
   end

   // read mux; the reload and soft-reset fields always read zero
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            DTAS_OFS_GAIN:    rdata_d = gain_q;
            DTAS_OFS_OFFSET:  rdata_d = offs_q;
            DTAS_OFS_CLRCODE: rdata_d = clrc_q;
            DTAS_OFS_ADCCFG:  rdata_d = acfg_q;
            DTAS_OFS_BOUNDS:  rdata_d = {8'h00, bnd_q};
            DTAS_OFS_TRIG:    rdata_d = {15'h0000, trig_q};
            DTAS_OFS_CONVCTL: rdata_d = {15'h0000, fclr_q};
            DTAS_OFS_STATUS:  rdata_d = {10'h000, alarm_q, conv_q, ch_q};
            default:          rdata_d = 16'h0000;
         endcase
      end
   end

   // converter code path: gain, offset, then clear-state override
   always_comb begin
      // code * (0.5 + gain/65536) = code*(32768+gain)/65536
      scaled = 34'(dac_code_in) * 34'({1'b0, gain_q} + 17'h08000);
      summed = 18'(scaled[32:16]) + 18'({{2{offs_q[15]}}, offs_q});
      if (summed[17])
         code_d = 16'h0000;
      else if (summed[16])
         code_d = 16'hFFFF;
      else
         code_d = summed[15:0];
      if (fclr_q) code_d = clrc_q;
   end

   // sequencer
   always_comb begin
      st_d   = st_q;
      ch_d   = ch_q;
      pre_d  = adc_tick ? 8'h00 : pre_q + 8'h01;
      tick_d = tick_q;
      conv_d = 1'b0;
      done_d = 1'b0;
      case (st_q)
         DTAS_IDLE: begin
            if (trig_q) begin
               st_d   = DTAS_CONV;
               ch_d   = start_idx; // index passed straight to the mux
               tick_d = conv_ticks(start_idx, acfg_q[DTAS_RATE_MSB:DTAS_RATE_LSB]) - 8'h01;
               conv_d = 1'b1;
            end
         end
         DTAS_CONV: begin
            if (!trig_q) begin
               st_d = DTAS_IDLE; // abort, no further channels
            end else if (adc_tick) begin
               if (tick_q != 8'h00) begin
                  tick_d = tick_q - 8'h01;
               end else begin
                  st_d = DTAS_NEXT;
                  // pulse per channel or after last only
                  done_d = acfg_q[DTAS_BIT_EOCCH] || (ch_q == stop_idx);
               end
            end
         end
         DTAS_NEXT: begin
            // a clear landing between channels must not start another one
            if (ch_q == stop_idx || !trig_q) begin
               st_d = DTAS_IDLE;
               ch_d = start_idx;
            end else begin
               st_d   = DTAS_CONV;
               ch_d   = ch_q + 4'h1;
               tick_d = conv_ticks(ch_q + 4'h1,
                                   acfg_q[DTAS_RATE_MSB:DTAS_RATE_LSB]) - 8'h01;
               conv_d = 1'b1;
            end
         end
         default: st_d = DTAS_IDLE;
      endcase
   end

   // successive fault counter; a good sample restarts the count
   always_comb begin
      fcnt_d  = fcnt_q;
      alarm_d = alarm_q;
      if (fault_sample) begin
         if (!fault_seen) begin
            fcnt_d  = 3'h0;
            alarm_d = 1'b0;
         end else if (fcnt_q >= acfg_q[DTAS_FLT_MSB:DTAS_FLT_LSB]) begin
            // limit lowered mid-count trips at once instead of wrapping
            alarm_d = 1'b1; // limit+1 faults in a row
         end else begin
            fcnt_d = fcnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_q  <= DTAS_RST_GAIN;
         offs_q  <= DTAS_RST_OFFSET;
         clrc_q  <= DTAS_RST_CLRCODE;
         acfg_q  <= DTAS_RST_ADCCFG;
         bnd_q   <= DTAS_RST_BOUNDS;
         fclr_q  <= 1'b0;
         trig_q  <= 1'b0;
         rel_q   <= 1'b0;
         srst_q  <= 1'b0;
         rdata_q <= 16'h0000;
         code_q  <= 16'h0000;
         st_q    <= DTAS_IDLE;
         ch_q    <= 4'h0;
         pre_q   <= 8'h00;
         tick_q  <= 8'h00;
         conv_q  <= 1'b0;
         done_q  <= 1'b0;
         fcnt_q  <= 3'h0;
         alarm_q <= 1'b0;
      end else begin
         gain_q  <= gain_d;
         offs_q  <= offs_d;
         clrc_q  <= clrc_d;
         acfg_q  <= acfg_d;
         bnd_q   <= bnd_d;
         fclr_q  <= fclr_d;
         trig_q  <= trig_d;
         rel_q   <= rel_d;
         srst_q  <= srst_d;
         rdata_q <= rdata_d;
         code_q  <= code_d;
         st_q    <= st_d;
         ch_q    <= ch_d;
         pre_q   <= pre_d;
         tick_q  <= tick_d;
         conv_q  <= conv_d;
         done_q  <= done_d;
         fcnt_q  <= fcnt_d;
         alarm_q <= alarm_d;
      end
   end

   assign reg_rdata            = rdata_q;
   assign dac_code_out         = code_q;
   assign soft_reset_pulse     = srst_q;
   assign trim_reload          = rel_q;
   assign adc_buffer_powerdown = acfg_q[DTAS_BIT_BUFPD];
   assign threshold_hysteresis = acfg_q[DTAS_THRESHOLD_HYSTERESIS_MSB:DTAS_THRESHOLD_HYSTERESIS_LSB];
   assign analog_input_span    = acfg_q[DTAS_BIT_SPAN]; // software's choice
   assign adc_channel          = ch_q;
   assign adc_convert          = conv_q;
   assign conversion_done      = done_q;
   assign alarm_trip           = alarm_q;

   a_key_reset: assert property (@(posedge clk) disable iff (!rst_n)
      is_wr(reg_addr, DTAS_OFS_SRESET)
      |=> soft_reset_pulse == (8'($past(reg_wdata)) == DTAS_RESET_KEY))
      else $error("soft reset not tied to key");

   a_reset_restores: assert property (@(posedge clk) disable iff (!rst_n)
      soft_reset_pulse |=> gain_q == DTAS_RST_GAIN && !trig_q)
      else $error("soft reset did not restore registers");

   a_clear_code: assert property (@(posedge clk) disable iff (!rst_n)
      fclr_q |=> dac_code_out == $past(clrc_q))
      else $error("clear code not applied");

   a_unity_gain: assert property (@(posedge clk) disable iff (!rst_n)
      (gain_q == DTAS_RST_GAIN && offs_q == 16'h0000 && !fclr_q)
      |=> dac_code_out == $past(dac_code_in))
      else $error("unity gain not transparent");

   a_stop_forced: assert property (@(posedge clk) disable iff (!rst_n)
      st_q != DTAS_IDLE |-> ch_q >= start_idx && ch_q <= stop_idx)
      else $error("channel outside sequence bounds");

   a_abort_seq: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == DTAS_CONV && !trig_q) |=> st_q == DTAS_IDLE && !adc_convert)
      else $error("sequence not aborted");

   a_abort_next: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == DTAS_NEXT && !trig_q) |=> st_q == DTAS_IDLE && !adc_convert)
      else $error("sequence continued after abort");

   a_direct_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_end && direct && !wr_trig && !srst_q) |=> !trig_q)
      else $error("direct trigger not cleared");

   a_auto_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_end && !direct && !wr_trig && !srst_q) |=> trig_q)
      else $error("auto trigger dropped");

   a_trig_write: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_trig && !srst_q) |=> trig_q == $past(reg_wdata[DTAS_BIT_ADCTRIG]))
      else $error("trigger write not taken");

   a_start_first: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == DTAS_IDLE && trig_q) |=> adc_convert && adc_channel == $past(start_idx))
      else $error("sequence not started at start index");

   a_next_channel: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == DTAS_NEXT && trig_q && ch_q != stop_idx)
      |=> adc_convert && adc_channel == $past(ch_q) + 4'h1)
      else $error("channel order broken");

   a_fixed_rate: assert property (@(posedge clk) disable iff (!rst_n)
      (adc_convert && adc_channel != DTAS_CH_EXT0 && adc_channel != DTAS_CH_EXT1)
      |-> tick_q == 8'(DTAS_TICKS_2560 - 1))
      else $error("fixed rate not applied");

   a_slow_rate: assert property (@(posedge clk) disable iff (!rst_n)
      (adc_convert && (adc_channel == DTAS_CH_EXT0 || adc_channel == DTAS_CH_EXT1)
      && $past(acfg_q[DTAS_RATE_MSB:DTAS_RATE_LSB]) == 2'h3)
      |-> tick_q == 8'(DTAS_TICKS_640 - 1))
      else $error("slowest rate not applied");

   a_eoc_each: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == DTAS_CONV && trig_q && adc_tick && tick_q == 8'h00
      && acfg_q[DTAS_BIT_EOCCH]) |=> conversion_done)
      else $error("per-channel done pulse missing");

   a_eoc_last: assert property (@(posedge clk) disable iff (!rst_n)
      (conversion_done && !acfg_q[DTAS_BIT_EOCCH]) |-> ch_q == stop_idx)
      else $error("done pulse before last channel");

   a_fault_trip: assert property (@(posedge clk) disable iff (!rst_n)
      (fault_sample && fault_seen && fcnt_q >= acfg_q[DTAS_FLT_MSB:DTAS_FLT_LSB])
      |=> alarm_trip)
      else $error("alarm not tripped at fault limit");

   a_fault_good: assert property (@(posedge clk) disable iff (!rst_n)
      (fault_sample && !fault_seen) |=> !alarm_trip && fcnt_q == 3'h0)
      else $error("good sample did not restart count");

   a_reload_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      (trim_reload && !wr_trig) |=> !trim_reload)
      else $error("reload not self-clearing");

   a_reload_source: assert property (@(posedge clk) disable iff (!rst_n)
      trim_reload |-> $past(wr_trig && reg_wdata[DTAS_BIT_RELOAD]))
      else $error("reload without trigger write");

   a_trig_readback: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(reg_rd) && $past(reg_addr) == DTAS_OFS_TRIG) |-> reg_rdata[15:1] == 15'h0)
      else $error("reserved trigger bits not zero");

   c_direct_seq: cover property (@(posedge clk) disable iff (!rst_n)
      seq_end && direct);
   c_abort: cover property (@(posedge clk) disable iff (!rst_n)
      st_q == DTAS_CONV && !trig_q);
   c_alarm: cover property (@(posedge clk) disable iff (!rst_n) $rose(alarm_trip));
   c_soft_reset: cover property (@(posedge clk) disable iff (!rst_n) soft_reset_pulse);
   c_each_channel: cover property (@(posedge clk) disable iff (!rst_n)
      conversion_done && acfg_q[DTAS_BIT_EOCCH] && ch_q != stop_idx);
endmodule // dtas_regs

// file: verif/tb.sv
/* tb: self-checking bench for dtas_regs; drives the register port, converter
   code and fault inputs, and models every result with integers and queues.
   Assumes dtas_pkg, one 10 MHz clock and ADC_DIV set to 2 for short runs. */
`timescale 1ns/1ns
module tb;
   import dtas_pkg::*;
   logic                   clk, rst_n, reg_wr, reg_rd, fault_seen, fault_sample;
   logic [DTAS_ADDR_W-1:0] reg_addr;
   logic [15:0]            reg_wdata, reg_rdata, dac_code_in, dac_code_out;
   logic                   soft_reset_pulse, trim_reload, adc_buffer_powerdown;
   logic [6:0]             threshold_hysteresis;
   logic                   analog_input_span, adc_convert, conversion_done, alarm_trip;
   logic [3:0]             adc_channel;
   logic [31:0]            seed;
   int                     n_mismatch, n_checks, n_done, n_srst, n_reload, cyc;
   int                     tq[$];
   logic [3:0]             chq[$];
   dtas_regs #(.ADC_DIV(2)) dtas_regs_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dac_code_in(dac_code_in), .dac_code_out(dac_code_out),
      .soft_reset_pulse(soft_reset_pulse), .trim_reload(trim_reload),
      .adc_buffer_powerdown(adc_buffer_powerdown),
      .threshold_hysteresis(threshold_hysteresis), .analog_input_span(analog_input_span),
      .adc_channel(adc_channel), .adc_convert(adc_convert),
      .conversion_done(conversion_done), .fault_seen(fault_seen),
      .fault_sample(fault_sample), .alarm_trip(alarm_trip));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // monitor: pulses are one cycle long, so sample every edge
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (adc_convert === 1'b1) begin
         chq.push_back(adc_channel);
         tq.push_back(cyc);
      end
      if (conversion_done === 1'b1) n_done <= n_done + 1;
      if (soft_reset_pulse === 1'b1) n_srst <= n_srst + 1;
      if (trim_reload === 1'b1) n_reload <= n_reload + 1;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask
   task automatic fault(input logic v);
      @(posedge clk);
      fault_sample <= 1'b1;
      fault_seen <= v;
      @(posedge clk);
      fault_sample <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // direct-mode sequence; checks channel order, dwell per channel and done pulses
   task automatic run_seq(input logic [15:0] cfg, input logic [3:0] st, input logic [3:0] sp);
      int q0, d0, k, e, nch, nd;
      logic [3:0] eff;
      eff = (sp < st) ? st : sp;
      nch = eff - st + 1;
      nd = cfg[3] ? nch : 1;
      wr(DTAS_OFS_ADCCFG, cfg);
      wr(DTAS_OFS_BOUNDS, {8'h00, sp, st});
      q0 = chq.size();
      d0 = n_done;
      wr(DTAS_OFS_TRIG, 16'h0001);
      k = 0;
      while (n_done - d0 < nd && k < 6000) begin
         @(posedge clk);
         k++;
      end
      repeat (300) @(posedge clk);
      chk(n_done - d0, nd);
      chk(chq.size() - q0, nch);
      for (int i = 0; i < nch && q0 + i < chq.size(); i++) begin
         chk(chq[q0 + i], st + i);
         if (i + 1 < nch && q0 + i + 1 < tq.size()) begin
            e = 60;
            if (chq[q0 + i] == DTAS_CH_EXT0 || chq[q0 + i] == DTAS_CH_EXT1)
               e = (cfg[2:1] == 2'h0) ? 40 : 30 << cfg[2:1];
            k = tq[q0 + i + 1] - tq[q0 + i];
            chk(k >= e && k <= e + 3, 1);
         end
      end
      rd(DTAS_OFS_TRIG, 16'h0000);
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      logic [15:0] g, o, c, cl;
      longint e;
      int d0;
      seed = 32'hEB3B;
      {rst_n, reg_wr, reg_rd, fault_seen, fault_sample} = 5'b0;
      reg_addr = '0;
      reg_wdata = 16'h0000;
      dac_code_in = 16'h0000;
      {n_mismatch, n_checks, n_done, n_srst, n_reload, cyc} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(DTAS_OFS_GAIN, 16'h8000);
      rd(DTAS_OFS_OFFSET, 16'h0000);
      rd(DTAS_OFS_CLRCODE, 16'h0000);
      rd(DTAS_OFS_ADCCFG, 16'h8810);
      rd(DTAS_OFS_BOUNDS, 16'h0080);
      rd(DTAS_OFS_TRIG, 16'h0000);
      chk({adc_buffer_powerdown, threshold_hysteresis, analog_input_span},
          9'h111);
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, 16'h0000);
      wr(DTAS_OFS_SRESET, 16'hFF12);
      rd(DTAS_OFS_SRESET, 16'h0000);
      wr(DTAS_OFS_BOUNDS, 16'hFF53);
      rd(DTAS_OFS_BOUNDS, 16'h0053);
      // field outputs follow a random configuration; direct bit kept clear
      c = rnd();
      c[0] = 1'b0;
      wr(DTAS_OFS_ADCCFG, c);
      rd(DTAS_OFS_ADCCFG, c);
      chk({adc_buffer_powerdown, threshold_hysteresis, analog_input_span},
          {c[15], c[14:8], c[4]});
      for (int i = 0; i < 6; i++) begin
         g = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : rnd();
         o = (i == 2) ? 16'hFFFF : rnd();
         c = rnd();
         dac_code_in <= c;
         wr(DTAS_OFS_GAIN, g);
         wr(DTAS_OFS_OFFSET, o);
         rd(DTAS_OFS_GAIN, g);
         repeat (3) @(posedge clk);
         e = (longint'(c) * (32768 + longint'(g))) / 65536 + longint'($signed(o));
         if (e < 0) e = 0;
         if (e > 65535) e = 65535;
         chk(dac_code_out, e[15:0]);
      end
      cl = rnd();
      wr(DTAS_OFS_CLRCODE, cl);
      wr(DTAS_OFS_CONVCTL, 16'h0001);
      repeat (3) @(posedge clk);
      chk(dac_code_out, cl);
      wr(DTAS_OFS_CONVCTL, 16'h0000);
      repeat (3) @(posedge clk);
      chk(dac_code_out, e[15:0]);
      // only the key value resets; the wrong key above must not pulse soft reset
      chk(n_srst, 0);
      wr(DTAS_OFS_SRESET, 16'h00AD);
      repeat (4) @(posedge clk);
      chk(n_srst, 1);
      rd(DTAS_OFS_GAIN, 16'h8000);
      rd(DTAS_OFS_SRESET, 16'h0000);
      wr(DTAS_OFS_TRIG, 16'h0002);
      repeat (3) @(posedge clk);
      chk(n_reload, 1);
      rd(DTAS_OFS_TRIG, 16'h0000);
      for (int r = 0; r < 4; r++)
         run_seq(16'h8801 | (r << 1) | (r[0] << 3), 4'h1, 4'h3);
      run_seq(16'h8809, 4'h9, 4'h4);
      run_seq(16'h8801, 4'h0, 4'hF);
      // abort mid-sequence: no done pulse and at most one further channel start
      wr(DTAS_OFS_BOUNDS, 16'h0080);
      d0 = n_done;
      wr(DTAS_OFS_TRIG, 16'h0001);
      repeat (100) @(posedge clk);
      wr(DTAS_OFS_TRIG, 16'h0000);
      g = chq.size();
      repeat (600) @(posedge clk);
      chk(n_done - d0, 0);
      chk(chq.size() - g <= 1, 1);
      // auto mode keeps converting until the bit is cleared
      wr(DTAS_OFS_ADCCFG, 16'h8810);
      wr(DTAS_OFS_BOUNDS, 16'h0000);
      d0 = n_done;
      wr(DTAS_OFS_TRIG, 16'h0001);
      repeat (400) @(posedge clk);
      chk(n_done - d0 >= 4, 1);
      wr(DTAS_OFS_TRIG, 16'h0000);
      repeat (100) @(posedge clk);
      d0 = n_done;
      repeat (300) @(posedge clk);
      chk(n_done, d0);
      for (int l = 0; l < 8; l += 7) begin
         wr(DTAS_OFS_ADCCFG, 16'h8810 | (l << 5));
         fault(1'b0);
         for (int f = 0; f < l; f++) fault(1'b1);
         chk(alarm_trip, 1'b0);
         fault(1'b1);
         chk(alarm_trip, 1'b1);
      end
      give_verdict();
   end
endmodule // tb
